/* rtl/dma_arb_defines.vh */
// Register offsets, field positions and timing counts of the DMA arbitration and interrupt block
`ifndef DMA_ARB_DEFINES_VH
`define DMA_ARB_DEFINES_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_GLOBAL_CTRL 12'h000
`define OFS_TRIG_SEL    12'h004
`define OFS_IRQ_VECTOR  12'h008
`define OFS_CH_CTRL     12'h00c
`define OFS_STATUS      12'h010
`define OFS_SIZE0       12'h014
`define OFS_SIZE1       12'h018
`define OFS_SIZE2       12'h01c

// ****************************************************************
// Global control fields
// ****************************************************************
`define GC_ROTATE     0
`define GC_NMI_ABORT  1
`define GC_GLOBAL_IE  2

// Channel control: enable in bits 2..0, irq enable in bits 6..4, done flags 10..8
`define CC_EN_LSB    0
`define CC_IE_LSB    4
`define CC_DONE_LSB  8

// ****************************************************************
// Trigger select codes and vector values
// ****************************************************************
`define TSEL_SOFTWARE 4'h0
`define TSEL_SERB_RX  4'hc
`define TSEL_SERB_TX  4'hd
`define TSEL_EXTERNAL 4'hf
`define VEC_NONE      4'h0
`define VEC_CH0       4'h2
`define VEC_CH1       4'h4
`define VEC_CH2       4'h6

// ****************************************************************
// Timing counts in main clock cycles; oscillator start-up and clock period in ns
// ****************************************************************
`define SYNC_CYCLES   2'h2
`define MOVE_CYCLES   2'h2
`define OSC_START_NS  6000
`define CLK_PERIOD_NS 5
`define OSC_START_CYCLES ((`OSC_START_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* rtl/dma_arbitration_and_irq.v */
// Three-channel DMA arbiter, transfer timing, completion flags and interrupt vector with APB registers
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "dma_arb_defines.vh"

// Notes on behaviour
// [R1] NMI aborts any transfer when enabled
// [R2] Clearing enable stops burst-block transfer
// [R3] Default rank zero, one, two
// [R4] Winner finishes whole transfer before next
// [R5] Running transfer is never preempted
// [R6] Rotating: finished channel becomes lowest
// [R7] Clearing rotate restores fixed ranking
// [R8] Synchronize trigger before each transfer
// [R9] Move two cycles, then one idle
// [R10] Clock running, CPU halted: no wake
// [R11] Clock stopped: restart it for transfer
// [R12] Single transfer within four or five cycles
// [R13] Maskable interrupts held during transfer
// [R14] Software disables controller for critical routines
// [R15] Done flag set when size reaches zero
// [R16] Irq when flag, enable, global all set
// [R17] Flags cleared only by software or vector
// [R18] Vector names highest enabled pending channel
// [R19] Vector access clears highest enabled flag
// [R20] Serial receive flag triggers unless enabled
// [R21] Serial transmit flag triggers unless enabled
// [R22] Code 1100 selects serial receive
// [R23] Code 1101 selects serial transmit
// [R24] Vector 0 none, 2/4/6 channels
module dma_arbitration_and_irq #(
  parameter OSC_START_CYCLES = `OSC_START_CYCLES,
  parameter SIZE_W           = 16
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        nmi,
  input  wire        cpu_halted,
  input  wire        main_clock_on,
  input  wire        osc_ready,
  input  wire        serial_b_rx_flag,
  input  wire        serial_b_tx_flag,
  input  wire        serial_b_rx_irq_enable,
  input  wire        serial_b_tx_irq_enable,
  input  wire        ext_trigger,
  input  wire [2:0]  burst_mode,
  output reg         serial_b_rx_ack,
  output reg         serial_b_tx_ack,
  output reg         move_strobe,
  output reg  [1:0]  move_channel,
  output reg         main_clock_request,
  output reg         hold_maskable_irq,
  output wire        dma_irq
);

  // ****************************************************************
  // States
  // ****************************************************************
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_WAKE = 5'h02;
  localparam [4:0] ST_SYNC = 5'h04;
  localparam [4:0] ST_MOVE = 5'h08;
  localparam [4:0] ST_GAP  = 5'h10;

  reg  [2:0]        gctrl_reg;
  reg  [11:0]       tsel_reg;
  reg  [2:0]        chen_reg;
  reg  [2:0]        chie_reg;
  reg  [2:0]        done_reg;
  reg  [2:0]        swtrig_reg;
  reg  [2:0]        pend_reg;
  reg  [SIZE_W-1:0] size_reg [0:2];
  reg  [4:0]        state_reg;
  reg  [1:0]        cur_reg;
  reg  [1:0]        cnt_reg;
  reg  [12:0]       wake_reg;
  reg  [1:0]        last_reg;
  reg  [2:0]        trig_d_reg;

  wire [2:0]        trig_raw;
  reg  [1:0]        pick;
  reg               pick_valid;
  reg  [3:0]        vec;
  reg  [2:0]        vec_clear;
  reg  [31:0]       rd_word;

  wire wr_en  = psel & penable & pwrite;
  wire acc_en = psel & penable;
  wire [2:0] irq_pending = done_reg & chie_reg;

  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // ****************************************************************
  // Trigger sources
  // ****************************************************************
  // Channel zero source
  dma_trigger_mux trig_mux0 (
    .code     (tsel_reg[3:0]),
    .sw_trig  (swtrig_reg[0]),
    .rx_flag  (serial_b_rx_flag),
    .rx_ie    (serial_b_rx_irq_enable),
    .tx_flag  (serial_b_tx_flag),
    .tx_ie    (serial_b_tx_irq_enable),
    .ext_trig (ext_trigger),
    .trig     (trig_raw[0])
  );

  // Channel one source
  dma_trigger_mux trig_mux1 (
    .code     (tsel_reg[7:4]),
    .sw_trig  (swtrig_reg[1]),
    .rx_flag  (serial_b_rx_flag),
    .rx_ie    (serial_b_rx_irq_enable),
    .tx_flag  (serial_b_tx_flag),
    .tx_ie    (serial_b_tx_irq_enable),
    .ext_trig (ext_trigger),
    .trig     (trig_raw[1])
  );

  // Channel two source
  dma_trigger_mux trig_mux2 (
    .code     (tsel_reg[11:8]),
    .sw_trig  (swtrig_reg[2]),
    .rx_flag  (serial_b_rx_flag),
    .rx_ie    (serial_b_rx_irq_enable),
    .tx_flag  (serial_b_tx_flag),
    .tx_ie    (serial_b_tx_irq_enable),
    .ext_trig (ext_trigger),
    .trig     (trig_raw[2])
  );

  // ****************************************************************
  // Arbiter: ranking starts after the last served channel when rotating
  // ****************************************************************
  always @* begin
    pick       = 2'h0;
    pick_valid = 1'b0;
    if (!gctrl_reg[`GC_ROTATE] || last_reg == 2'h2) begin // [R3] [R7]
      if (pend_reg[0]) begin
        pick = 2'h0; pick_valid = 1'b1;
      end else if (pend_reg[1]) begin
        pick = 2'h1; pick_valid = 1'b1;
      end else if (pend_reg[2]) begin
        pick = 2'h2; pick_valid = 1'b1;
      end
    end else if (last_reg == 2'h0) begin // [R6]
      if (pend_reg[1]) begin
        pick = 2'h1; pick_valid = 1'b1;
      end else if (pend_reg[2]) begin
        pick = 2'h2; pick_valid = 1'b1;
      end else if (pend_reg[0]) begin
        pick = 2'h0; pick_valid = 1'b1;
      end
    end else begin
      if (pend_reg[2]) begin
        pick = 2'h2; pick_valid = 1'b1;
      end else if (pend_reg[0]) begin
        pick = 2'h0; pick_valid = 1'b1;
      end else if (pend_reg[1]) begin
        pick = 2'h1; pick_valid = 1'b1;
      end
    end
  end

  // ****************************************************************
  // Interrupt vector, channel zero first
  // ****************************************************************
  always @* begin
    vec       = `VEC_NONE; // [R24]
    vec_clear = 3'h0;
    if (irq_pending[0]) begin // [R18]
      vec = `VEC_CH0; vec_clear = 3'h1;
    end else if (irq_pending[1]) begin
      vec = `VEC_CH1; vec_clear = 3'h2;
    end else if (irq_pending[2]) begin
      vec = `VEC_CH2; vec_clear = 3'h4;
    end
  end

  assign dma_irq = (|irq_pending) & gctrl_reg[`GC_GLOBAL_IE]; // [R16]

  // ****************************************************************
  // Register file and transfer engine
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gctrl_reg          <= 3'h0;
      tsel_reg           <= 12'h000;
      chen_reg           <= 3'h0;
      chie_reg           <= 3'h0;
      done_reg           <= 3'h0;
      swtrig_reg         <= 3'h0;
      pend_reg           <= 3'h0;
      size_reg[0]        <= {SIZE_W{1'b0}};
      size_reg[1]        <= {SIZE_W{1'b0}};
      size_reg[2]        <= {SIZE_W{1'b0}};
      state_reg          <= ST_IDLE;
      cur_reg            <= 2'h0;
      cnt_reg            <= 2'h0;
      wake_reg           <= 13'h0000;
      last_reg           <= 2'h2;
      trig_d_reg         <= 3'h0;
      serial_b_rx_ack    <= 1'b0;
      serial_b_tx_ack    <= 1'b0;
      move_strobe        <= 1'b0;
      move_channel       <= 2'h0;
      main_clock_request <= 1'b0;
      hold_maskable_irq  <= 1'b0;
    end else begin
      serial_b_rx_ack <= 1'b0;
      serial_b_tx_ack <= 1'b0;
      move_strobe     <= 1'b0;
      swtrig_reg      <= 3'h0;
      trig_d_reg      <= trig_raw;
      // Rising edges only, so a level flag cannot retrigger before it is acknowledged
      pend_reg <= pend_reg | (trig_raw & ~trig_d_reg & chen_reg); // [R4]

      if (acc_en && paddr == `OFS_IRQ_VECTOR)
        done_reg <= done_reg & ~vec_clear; // [R19] [R17]
      if (wr_en) begin
        case (paddr)
          `OFS_GLOBAL_CTRL: gctrl_reg <= pwdata[2:0];
          `OFS_TRIG_SEL:    tsel_reg  <= pwdata[11:0];
          `OFS_CH_CTRL: begin
            chen_reg   <= pwdata[`CC_EN_LSB +: 3];
            chie_reg   <= pwdata[`CC_IE_LSB +: 3];
            done_reg   <= done_reg & pwdata[`CC_DONE_LSB +: 3]; // [R17]
            swtrig_reg <= pwdata[14:12];
          end
          `OFS_SIZE0: size_reg[0] <= pwdata[SIZE_W-1:0];
          `OFS_SIZE1: size_reg[1] <= pwdata[SIZE_W-1:0];
          `OFS_SIZE2: size_reg[2] <= pwdata[SIZE_W-1:0];
          default: ;
        endcase
      end
      if (!gctrl_reg[`GC_ROTATE])
        last_reg <= 2'h2; // [R7]

      case (state_reg)
        ST_IDLE: begin
          main_clock_request <= 1'b0;
          hold_maskable_irq  <= 1'b0;
          if (pick_valid) begin // [R5]
            cur_reg            <= pick;
            pend_reg[pick]     <= 1'b0;
            hold_maskable_irq  <= 1'b1; // [R13] [R10]
            main_clock_request <= ~main_clock_on; // [R11]
            cnt_reg            <= 2'h0;
            wake_reg           <= 13'h0000;
            serial_b_rx_ack    <= (tsel_reg[pick*4 +: 4] == `TSEL_SERB_RX); // [R20]
            serial_b_tx_ack    <= (tsel_reg[pick*4 +: 4] == `TSEL_SERB_TX); // [R21]
            state_reg          <= main_clock_on ? ST_SYNC : ST_WAKE;
          end
        end
        ST_WAKE: begin
          // Oscillator start-up bounded so a dead oscillator cannot hang the engine
          wake_reg <= wake_reg + 13'h0001;
          if (osc_ready || wake_reg >= OSC_START_CYCLES[12:0]) // [R12] [R11]
            state_reg <= ST_SYNC;
        end
        ST_SYNC: begin
          cnt_reg <= cnt_reg + 2'h1;
          if (cnt_reg == `SYNC_CYCLES - 2'h1) begin // [R8]
            cnt_reg   <= 2'h0;
            state_reg <= ST_MOVE;
          end
        end
        ST_MOVE: begin
          cnt_reg <= cnt_reg + 2'h1;
          if (cnt_reg == `MOVE_CYCLES - 2'h1) begin // [R9] [R12]
            move_strobe  <= 1'b1;
            move_channel <= cur_reg;
            cnt_reg      <= 2'h0;
            if (size_reg[cur_reg] != {SIZE_W{1'b0}})
              size_reg[cur_reg] <= size_reg[cur_reg] - {{(SIZE_W-1){1'b0}}, 1'b1};
            if (size_reg[cur_reg] <= {{(SIZE_W-1){1'b0}}, 1'b1})
              done_reg[cur_reg] <= 1'b1; // [R15]
            state_reg <= ST_GAP;
          end
        end
        ST_GAP: begin // [R9]
          if (size_reg[cur_reg] == {SIZE_W{1'b0}} || !burst_mode[cur_reg]) begin
            last_reg  <= gctrl_reg[`GC_ROTATE] ? cur_reg : 2'h2; // [R6] [R4]
            state_reg <= ST_IDLE;
          end else begin
            state_reg <= ST_MOVE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase

      if (state_reg != ST_IDLE) begin
        if ((nmi && gctrl_reg[`GC_NMI_ABORT]) || // [R1]
            (burst_mode[cur_reg] && !chen_reg[cur_reg])) begin // [R2]
          state_reg <= ST_IDLE;
        end
      end
    end
  end

  // ****************************************************************
  // Read data, registered at the setup phase
  // ****************************************************************
  // Vector is captured before the access phase clears its flag
  always @* begin
    case (paddr)
      `OFS_GLOBAL_CTRL: rd_word = {29'h0, gctrl_reg};
      `OFS_TRIG_SEL:    rd_word = {20'h0, tsel_reg};
      `OFS_IRQ_VECTOR:  rd_word = {28'h0, vec}; // [R18]
      `OFS_CH_CTRL:     rd_word = {21'h0, done_reg, 1'b0, chie_reg, 1'b0, chen_reg};
      `OFS_STATUS:      rd_word = {22'h0, cur_reg, 3'h0, state_reg};
      `OFS_SIZE0:       rd_word = {{(32-SIZE_W){1'b0}}, size_reg[0]};
      `OFS_SIZE1:       rd_word = {{(32-SIZE_W){1'b0}}, size_reg[1]};
      `OFS_SIZE2:       rd_word = {{(32-SIZE_W){1'b0}}, size_reg[2]};
      default:          rd_word = 32'h00000000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_word;
    end
  end

endmodule // dma_arbitration_and_irq

// ****************************************************************
// Per-channel trigger source selection
// ****************************************************************
module dma_trigger_mux (
  input  wire [3:0] code,
  input  wire       sw_trig,
  input  wire       rx_flag,
  input  wire       rx_ie,
  input  wire       tx_flag,
  input  wire       tx_ie,
  input  wire       ext_trig,
  output reg        trig
);

  always @* begin
    case (code)
      `TSEL_SOFTWARE: trig = sw_trig;
      `TSEL_SERB_RX:  trig = rx_flag & ~rx_ie; // [R22] [R20]
      `TSEL_SERB_TX:  trig = tx_flag & ~tx_ie; // [R23] [R21]
      `TSEL_EXTERNAL: trig = ext_trig;
      // Unused codes never fire, so a stale select cannot start a transfer
      default:        trig = 1'b0;
    endcase
  end

endmodule // dma_trigger_mux

/* verification/serial_b_model.sv */
// Far-side model: serial unit B event flags and the oscillator start-up
`timescale 1ns/1ps
module serial_b_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic set_rx,
  input  wire logic set_tx,
  input  wire logic rx_ack,
  input  wire logic tx_ack,
  input  wire logic clk_req,
  output logic      rx_flag,
  output logic      tx_flag,
  output logic      osc_ready
);
  logic [3:0] osc_cnt;
  // Flags stay up until acknowledged, so a late ack shows as a stuck flag
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_flag <= 1'b0;
      tx_flag <= 1'b0;
      osc_cnt <= 4'h0;
    end else begin
      rx_flag <= set_rx | (rx_flag & !rx_ack);
      tx_flag <= set_tx | (tx_flag & !tx_ack);
      osc_cnt <= clk_req ? osc_cnt + {3'h0, osc_cnt != 4'h8} : 4'h0;
    end
  end
  assign osc_ready = (osc_cnt == 4'h8);
endmodule // serial_b_model

/* verification/dma_arb_assertions.sv */
// Port-level checks of transfer timing, clock wake-up and serial acks
`timescale 1ns/1ps
module dma_arb_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic move_strobe,
  input wire logic main_clock_on,
  input wire logic main_clock_request,
  input wire logic hold_maskable_irq,
  input wire logic serial_b_rx_flag,
  input wire logic serial_b_tx_flag,
  input wire logic serial_b_rx_ack,
  input wire logic serial_b_tx_ack
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence sync_s;
    !move_strobe [*3];
  endsequence
  sequence gap_s;
    !move_strobe [*2];
  endsequence
  sync_time_a: assert property ($rose(hold_maskable_irq) && main_clock_on |-> sync_s ##[1:3] move_strobe)
    else $error("first move not on time");
  strobe_gap_a: assert property (move_strobe |=> gap_s)
    else $error("moves too close");
  strobe_in_xfer_a: assert property (move_strobe |-> hold_maskable_irq)
    else $error("interrupts not held during move");
  rx_ack_a: assert property (serial_b_rx_ack |-> $past(serial_b_rx_flag) ##1 !serial_b_rx_ack)
    else $error("bad receive ack");
  tx_ack_a: assert property (serial_b_tx_ack |-> $past(serial_b_tx_flag) ##1 !serial_b_tx_ack)
    else $error("bad transmit ack");
  clk_wake_a: assert property ($rose(main_clock_request) |-> !$past(main_clock_on))
    else $error("clock requested while running");
  clk_release_a: assert property ($fell(hold_maskable_irq) |-> ##[0:1] !main_clock_request)
    else $error("clock kept after transfer");
  strobe_clock_a: assert property (move_strobe && !main_clock_on |-> main_clock_request)
    else $error("move without clock");
endmodule // dma_arb_checker

bind dma_arbitration_and_irq dma_arb_checker chk_i (.pclk(pclk), .presetn(presetn), .move_strobe(move_strobe),
  .main_clock_on(main_clock_on), .main_clock_request(main_clock_request), .hold_maskable_irq(hold_maskable_irq),
  .serial_b_rx_flag(serial_b_rx_flag), .serial_b_tx_flag(serial_b_tx_flag),
  .serial_b_rx_ack(serial_b_rx_ack), .serial_b_tx_ack(serial_b_tx_ack));

/* verification/test_dma_arbitration_and_irq.sv */
// Self-checking bench for the DMA arbiter and interrupt block
`timescale 1ns/1ps
`include "dma_arb_defines.vh"
module test_dma_arbitration_and_irq;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd_v;
  logic        pready, pslverr, rx_flag, tx_flag, osc_ready, rx_ack, tx_ack, move_strobe, clk_req, hold, dma_irq;
  logic        nmi = 1'b0, clk_on = 1'b1, rx_ie = 1'b0, tx_ie = 1'b0, set_rx = 1'b0, set_tx = 1'b0, req_seen = 1'b0;
  logic [2:0]  burst_mode = 3'h0;
  logic [1:0]  move_channel;
  logic [1:0]  seen[$];
  int          errors = 0, n_checks = 0;

  dma_arbitration_and_irq #(.OSC_START_CYCLES(10)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .nmi(nmi), .cpu_halted(1'b1), .main_clock_on(clk_on), .osc_ready(osc_ready),
    .serial_b_rx_flag(rx_flag), .serial_b_tx_flag(tx_flag), .serial_b_rx_irq_enable(rx_ie),
    .serial_b_tx_irq_enable(tx_ie), .ext_trigger(1'b0), .burst_mode(burst_mode), .serial_b_rx_ack(rx_ack),
    .serial_b_tx_ack(tx_ack), .move_strobe(move_strobe), .move_channel(move_channel),
    .main_clock_request(clk_req), .hold_maskable_irq(hold), .dma_irq(dma_irq));
  serial_b_model far (.pclk(pclk), .presetn(presetn), .set_rx(set_rx), .set_tx(set_tx), .rx_ack(rx_ack),
    .tx_ack(tx_ack), .clk_req(clk_req), .rx_flag(rx_flag), .tx_flag(tx_flag), .osc_ready(osc_ready));

  initial forever #2.5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (move_strobe === 1'b1) seen.push_back(move_channel);
    if (clk_req === 1'b1) req_seen <= 1'b1;
  end

  // ****************************************************************
  // Bus cycles and comparisons
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd_v = prdata;
    chk({pready, pslverr}, 2'b10);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Clears all done flags, so each scenario starts from a clean vector
  task automatic sizes(input logic [31:0] n);
    bus(1'b1, `OFS_CH_CTRL, 32'h77);
    bus(1'b1, `OFS_SIZE0, n);
    bus(1'b1, `OFS_SIZE1, n);
    bus(1'b1, `OFS_SIZE2, n);
    seen.delete();
  endtask
  task automatic trig(input logic [2:0] m);
    bus(1'b1, `OFS_CH_CTRL, {17'h0, m, 12'h777});
  endtask
  task automatic moves(input int k);
    repeat (400) if (seen.size() < k) @(posedge pclk);
    repeat (4) @(posedge pclk);
  endtask
  task automatic order(input int n, input logic [7:0] e);
    chk(seen.size(), n);
    for (int i = 0; i < n; i++) chk(seen[i], e[2*i +: 2]);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_vector;
    bus(1'b1, `OFS_GLOBAL_CTRL, 32'h4);
    sizes(1);
    trig(3'b101);
    moves(2);
    order(2, 8'h08);
    chk(dma_irq, 1);
    bus(1'b0, `OFS_IRQ_VECTOR, 0);
    chk(rd_v, `VEC_CH0);
    bus(1'b1, `OFS_CH_CTRL, 32'h737);
    bus(1'b0, `OFS_IRQ_VECTOR, 0);
    chk({rd_v[3:0], dma_irq}, {`VEC_NONE, 1'b0});
    bus(1'b1, `OFS_CH_CTRL, 32'h777);
    bus(1'b0, `OFS_IRQ_VECTOR, 0);
    chk(rd_v, `VEC_CH2);
    bus(1'b1, `OFS_IRQ_VECTOR, 0);
    bus(1'b0, `OFS_IRQ_VECTOR, 0);
    chk({rd_v[3:0], dma_irq}, {`VEC_NONE, 1'b0});
  endtask
  task automatic t_preempt;
    burst_mode <= 3'b100;
    sizes(3);
    trig(3'b100);
    trig(3'b001);
    moves(4);
    order(4, 8'h2a);
    bus(1'b0, `OFS_CH_CTRL, 0);
    chk(rd_v[10:8], 3'b100);
    burst_mode <= 3'b000;
  endtask
  task automatic t_rotate;
    bus(1'b1, `OFS_GLOBAL_CTRL, 32'h5);
    sizes(1);
    trig(3'b001);
    moves(1);
    sizes(1);
    trig(3'b111);
    moves(3);
    order(3, 8'h09);
    bus(1'b1, `OFS_GLOBAL_CTRL, 32'h4);
    sizes(1);
    trig(3'b111);
    moves(3);
    order(3, 8'h24);
  endtask
  task automatic t_abort;
    bus(1'b1, `OFS_GLOBAL_CTRL, 32'h6);
    burst_mode <= 3'b001;
    sizes(8);
    trig(3'b001);
    moves(2);
    nmi <= 1'b1;
    repeat (30) @(posedge pclk);
    nmi <= 1'b0;
    chk(seen.size() < 8, 1);
    sizes(8);
    trig(3'b001);
    moves(2);
    bus(1'b1, `OFS_CH_CTRL, 32'h776);
    repeat (30) @(posedge pclk);
    chk(seen.size() < 8, 1);
    burst_mode <= 3'b000;
  endtask
  // A blocked flag must stay pending and fire once its enable drops
  task automatic t_serial(input logic tx);
    bus(1'b1, `OFS_TRIG_SEL, tx ? {28'h0, `TSEL_SERB_TX} : {28'h0, `TSEL_SERB_RX});
    sizes(1);
    {tx_ie, rx_ie} <= 2'b11;
    {set_tx, set_rx} <= {tx, !tx};
    @(posedge pclk);
    {set_tx, set_rx} <= 2'b00;
    repeat (20) @(posedge pclk);
    chk({seen.size() == 0, tx_flag, rx_flag}, {1'b1, tx, !tx});
    {tx_ie, rx_ie} <= 2'b00;
    moves(1);
    chk({seen.size() == 1, tx_flag, rx_flag}, 3'b100);
    bus(1'b1, `OFS_TRIG_SEL, 0);
  endtask
  task automatic t_clkoff;
    chk(req_seen, 0);
    // Software quiets the engine: triggers with every channel off must not move
    seen.delete();
    bus(1'b1, `OFS_CH_CTRL, 32'h7070);
    repeat (20) @(posedge pclk);
    chk(seen.size(), 0);
    clk_on <= 1'b0;
    sizes(1);
    trig(3'b010);
    moves(1);
    chk({seen.size() == 1, req_seen, clk_req}, 3'b110);
    clk_on <= 1'b1;
  endtask

  task automatic end_sim;
    if (errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_vector;
    t_preempt;
    t_rotate;
    t_abort;
    t_serial(1'b0);
    t_serial(1'b1);
    t_clkoff;
    end_sim;
  end
  // Whole run needs well under 4000 cycles
  initial begin
    #100000;
    errors++;
    end_sim;
  end
endmodule // test_dma_arbitration_and_irq
